// ===== src/ifeb_bank.sv
// Interrupt flag and enable bank with register port and event interrupt
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module ifeb_bank (
    input  wire logic                      mclk,
    input  wire logic                      sys_rst,
    input  wire ifeb_pkg::ifeb_bus_req_type bus_req,
    output var  logic [ifeb_pkg::DATA_W-1:0] bus_rdata,
    input  wire ifeb_pkg::ifeb_flag_set_type src_set,
    input  wire logic [ifeb_pkg::DATA_W-1:0] flags_0_in,
    input  wire ifeb_pkg::ifeb_prio_type     prio_0,
    output var  ifeb_pkg::ifeb_flag_set_type flags_out,
    output var  logic [ifeb_pkg::DATA_W-1:0] enables_0,
    output var  logic [ifeb_pkg::DATA_W-1:0] pending_0,
    output var  logic                        irq
);
    import ifeb_pkg::*;

    // ************************************************************
    // Decode
    // ************************************************************
    logic              wr_flags_1;
    logic              wr_flags_2;
    logic              wr_flags_3;
    logic              wr_flags_4;
    logic              wr_enables_0;
    logic              wr_evt_mask;
    logic              rd_evt_status;
    logic [3:0]        evt_status;
    logic [3:0]        evt_mask;
    logic [3:0]        new_event;
    logic [DATA_W-1:0] next_rdata;
    logic [DATA_W-1:0] prio_live;
    logic [3:0]        next_status;
    logic [3:0]        next_mask;

    assign wr_flags_1    = bus_req.wr && (bus_req.addr == OFS_FLAGS_1);
    assign wr_flags_2    = bus_req.wr && (bus_req.addr == OFS_FLAGS_2);
    assign wr_flags_3    = bus_req.wr && (bus_req.addr == OFS_FLAGS_3);
    assign wr_flags_4    = bus_req.wr && (bus_req.addr == OFS_FLAGS_4);
    assign wr_enables_0  = bus_req.wr && (bus_req.addr == OFS_ENABLES_0);
    assign wr_evt_mask   = bus_req.wr && (bus_req.addr == OFS_EVT_MASK);
    assign rd_evt_status = bus_req.rd && (bus_req.addr == OFS_EVT_STATUS);

    // ************************************************************
    // Flag registers
    // ************************************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_out.flags_1 <= RST_REG;
        end else if (wr_flags_1) begin
            flags_out.flags_1 <= (bus_req.wdata | src_set.flags_1) & MASK_FLAGS_1;
        end else begin
            flags_out.flags_1 <= (flags_out.flags_1 | src_set.flags_1) & MASK_FLAGS_1;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_out.flags_2 <= RST_REG;
        end else if (wr_flags_2) begin
            flags_out.flags_2 <= (bus_req.wdata | src_set.flags_2) & MASK_FLAGS_2;
        end else begin
            flags_out.flags_2 <= (flags_out.flags_2 | src_set.flags_2) & MASK_FLAGS_2;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_out.flags_3 <= RST_REG;
        end else if (wr_flags_3) begin
            flags_out.flags_3 <= (bus_req.wdata | src_set.flags_3) & MASK_FLAGS_3;
        end else begin
            flags_out.flags_3 <= (flags_out.flags_3 | src_set.flags_3) & MASK_FLAGS_3;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            flags_out.flags_4 <= RST_REG;
        end else if (wr_flags_4) begin
            flags_out.flags_4 <= (bus_req.wdata | src_set.flags_4) & MASK_FLAGS_4;
        end else begin
            flags_out.flags_4 <= (flags_out.flags_4 | src_set.flags_4) & MASK_FLAGS_4;
        end
    end

    // ************************************************************
    // Enable register
    // ************************************************************
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            enables_0 <= RST_REG;
        end else if (wr_enables_0) begin
            enables_0 <= bus_req.wdata & MASK_ENABLES_0;
        end
    end

    // ************************************************************
    // Pending toward the priority logic
    // ************************************************************
    always_comb begin
        prio_live = '0;
        for (int i = 0; i < DATA_W; i++) begin
            prio_live[i] = |prio_0[i];
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pending_0 <= RST_REG;
        end else begin
            pending_0 <= flags_0_in & enables_0 & MASK_ENABLES_0 & prio_live;
        end
    end

    // ************************************************************
    // Event status, mask and interrupt
    // ************************************************************
    assign new_event[0] = |(src_set.flags_1 & MASK_FLAGS_1 & ~flags_out.flags_1);
    assign new_event[1] = |(src_set.flags_2 & MASK_FLAGS_2 & ~flags_out.flags_2);
    assign new_event[2] = |(src_set.flags_3 & MASK_FLAGS_3 & ~flags_out.flags_3);
    assign new_event[3] = |(src_set.flags_4 & MASK_FLAGS_4 & ~flags_out.flags_4);

    // Event in the cycle of the clearing read survives
    assign next_status = rd_evt_status ? new_event : (evt_status | new_event);
    // Irq follows a mask write in the same cycle as the mask itself
    assign next_mask   = wr_evt_mask ? bus_req.wdata[3:0] : evt_mask;

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            evt_status <= RST_EVT;
        end else begin
            evt_status <= next_status;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            evt_mask <= RST_EVT;
        end else begin
            evt_mask <= next_mask;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(next_status & next_mask);
        end
    end

    // ************************************************************
    // Read port
    // ************************************************************
    always_comb begin
        next_rdata = '0;
        unique case (bus_req.addr)
            OFS_FLAGS_1:    next_rdata = flags_out.flags_1;
            OFS_FLAGS_2:    next_rdata = flags_out.flags_2;
            OFS_FLAGS_3:    next_rdata = flags_out.flags_3;
            OFS_FLAGS_4:    next_rdata = flags_out.flags_4;
            OFS_ENABLES_0:  next_rdata = enables_0;
            OFS_EVT_STATUS: next_rdata = {12'h000, evt_status};
            OFS_EVT_MASK:   next_rdata = {12'h000, evt_mask};
            default:        next_rdata = '0;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata <= RST_REG;
        end else if (bus_req.rd) begin
            bus_rdata <= next_rdata;
        end else begin
            bus_rdata <= RST_REG;
        end
    end

endmodule : ifeb_bank
`default_nettype wire

// ===== src/ifeb_pkg.sv
// Constants, field layouts and carrier types for the interrupt flag and enable bank
package ifeb_pkg;

    // ************************************************************
    // Register bus
    // ************************************************************
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned PRIO_W = 3;

    localparam logic [ADDR_W-1:0] OFS_FLAGS_1    = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_FLAGS_2    = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_FLAGS_3    = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_FLAGS_4    = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_ENABLES_0  = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 3'h5;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK   = 3'h6;

    // ************************************************************
    // Implemented bit masks
    // ************************************************************
    localparam logic [DATA_W-1:0] MASK_FLAGS_1   = 16'hfe1f;
    localparam logic [DATA_W-1:0] MASK_FLAGS_2   = 16'h22e3;
    localparam logic [DATA_W-1:0] MASK_FLAGS_3   = 16'h4066;
    localparam logic [DATA_W-1:0] MASK_FLAGS_4   = 16'h000e;
    localparam logic [DATA_W-1:0] MASK_ENABLES_0 = 16'h3fef;

    localparam logic [DATA_W-1:0] RST_REG        = 16'h0000;
    localparam logic [3:0]        RST_EVT        = 4'h0;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned BIT_UART_B_TX_FLAG     = 15;
    localparam int unsigned BIT_UART_B_RX_FLAG     = 14;
    localparam int unsigned BIT_EXT_IN_TWO_FLAG    = 13;
    localparam int unsigned BIT_TIMER_FIVE_FLAG    = 12;
    localparam int unsigned BIT_TIMER_FOUR_FLAG    = 11;
    localparam int unsigned BIT_COMPARE_FOUR_FLAG  = 10;
    localparam int unsigned BIT_COMPARE_THREE_FLAG = 9;
    localparam int unsigned BIT_EXT_IN_ONE_FLAG    = 4;
    localparam int unsigned BIT_CHANGE_NOTIFY_FLAG = 3;
    localparam int unsigned BIT_COMPARATOR_FLAG    = 2;
    localparam int unsigned BIT_I2C_A_MASTER_FLAG  = 1;
    localparam int unsigned BIT_I2C_A_SLAVE_FLAG   = 0;
    localparam int unsigned BIT_PARALLEL_PORT_FLAG = 13;
    localparam int unsigned BIT_COMPARE_FIVE_FLAG  = 9;
    localparam int unsigned BIT_CAPTURE_FIVE_FLAG  = 7;
    localparam int unsigned BIT_CAPTURE_FOUR_FLAG  = 6;
    localparam int unsigned BIT_CAPTURE_THREE_FLAG = 5;
    localparam int unsigned BIT_SPI_B_EVENT_FLAG   = 1;
    localparam int unsigned BIT_SPI_B_FAULT_FLAG   = 0;
    localparam int unsigned BIT_CALENDAR_FLAG      = 14;
    localparam int unsigned BIT_EXT_IN_FOUR_FLAG   = 6;
    localparam int unsigned BIT_EXT_IN_THREE_FLAG  = 5;
    localparam int unsigned BIT_I2C_B_MASTER_FLAG  = 2;
    localparam int unsigned BIT_I2C_B_SLAVE_FLAG   = 1;
    localparam int unsigned BIT_CHECKSUM_GEN_FLAG  = 3;
    localparam int unsigned BIT_UART_B_ERROR_FLAG  = 2;
    localparam int unsigned BIT_UART_A_ERROR_FLAG  = 1;
    localparam int unsigned BIT_ADC_DONE_ENABLE    = 13;
    localparam int unsigned BIT_UART_A_TX_ENABLE   = 12;
    localparam int unsigned BIT_UART_A_RX_ENABLE   = 11;
    localparam int unsigned BIT_SPI_A_DONE_ENABLE  = 10;
    localparam int unsigned BIT_SPI_A_FAULT_ENABLE = 9;
    localparam int unsigned BIT_TIMER_THREE_ENABLE = 8;
    localparam int unsigned BIT_TIMER_TWO_ENABLE   = 7;
    localparam int unsigned BIT_COMPARE_TWO_ENABLE = 6;
    localparam int unsigned BIT_CAPTURE_TWO_ENABLE = 5;
    localparam int unsigned BIT_TIMER_ONE_ENABLE   = 3;
    localparam int unsigned BIT_COMPARE_ONE_ENABLE = 2;
    localparam int unsigned BIT_CAPTURE_ONE_ENABLE = 1;
    localparam int unsigned BIT_EXT_IN_ZERO_ENABLE = 0;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } ifeb_bus_req_type;

    typedef struct packed {
        logic [DATA_W-1:0] flags_1;
        logic [DATA_W-1:0] flags_2;
        logic [DATA_W-1:0] flags_3;
        logic [DATA_W-1:0] flags_4;
    } ifeb_flag_set_type;

    typedef logic [DATA_W-1:0][PRIO_W-1:0] ifeb_prio_type;

endpackage : ifeb_pkg

// ===== verif/ifeb_bank_sva.sv
// Port assertions for the flag and enable bank
`timescale 1ns/1ps
`default_nettype none
module ifeb_bank_sva (
    input wire logic                          mclk,
    input wire logic                          sys_rst,
    input wire ifeb_pkg::ifeb_bus_req_type    bus_req,
    input wire logic [ifeb_pkg::DATA_W-1:0]   bus_rdata,
    input wire ifeb_pkg::ifeb_flag_set_type   src_set,
    input wire logic [ifeb_pkg::DATA_W-1:0]   flags_0_in,
    input wire ifeb_pkg::ifeb_prio_type       prio_0,
    input wire ifeb_pkg::ifeb_flag_set_type   flags_out,
    input wire logic [ifeb_pkg::DATA_W-1:0]   enables_0,
    input wire logic [ifeb_pkg::DATA_W-1:0]   pending_0,
    input wire logic                          irq
);
    import ifeb_pkg::*;
    localparam logic [63:0] M_ALL = {MASK_FLAGS_1, MASK_FLAGS_2, MASK_FLAGS_3, MASK_FLAGS_4};
    logic [DATA_W-1:0] prio_on;
    logic [DATA_W-1:0] view;
    always_comb begin
        for (int i = 0; i < DATA_W; i++) begin
            prio_on[i] = |prio_0[i];
        end
        case (bus_req.addr)
            OFS_FLAGS_1:   view = flags_out.flags_1;
            OFS_FLAGS_2:   view = flags_out.flags_2;
            OFS_FLAGS_3:   view = flags_out.flags_3;
            OFS_FLAGS_4:   view = flags_out.flags_4;
            OFS_ENABLES_0: view = enables_0;
            default:       view = '0;
        endcase
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    property p_rst;
        disable iff (1'b0) sys_rst |-> flags_out == '0 && enables_0 == '0 && !irq;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear in reset");
    property p_unimpl;
        (flags_out & ~M_ALL) == '0 && (enables_0 & ~MASK_ENABLES_0) == '0;
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented bit set");
    property p_set;
        (src_set & M_ALL) != '0 |=> (flags_out & $past(src_set & M_ALL)) == $past(src_set & M_ALL);
    endproperty
    a_set: assert property (p_set) else $error("source request not recorded");
    property p_hold;
        !bus_req.wr && src_set == '0 |=> $stable(flags_out);
    endproperty
    a_hold: assert property (p_hold) else $error("flag changed without cause");
    property p_wr_f1;
        bus_req.wr && bus_req.addr == OFS_FLAGS_1 && src_set.flags_1 == '0
            |=> flags_out.flags_1 == ($past(bus_req.wdata) & MASK_FLAGS_1);
    endproperty
    a_wr_f1: assert property (p_wr_f1) else $error("flag write wrong");
    property p_wr_en;
        bus_req.wr && bus_req.addr == OFS_ENABLES_0
            |=> enables_0 == ($past(bus_req.wdata) & MASK_ENABLES_0);
    endproperty
    a_wr_en: assert property (p_wr_en) else $error("enable write wrong");
    property p_rd;
        bus_req.rd && (bus_req.addr < OFS_EVT_STATUS || bus_req.addr == 3'h7)
            |=> bus_rdata == $past(view);
    endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    property p_idle;
        !bus_req.rd |=> bus_rdata == '0;
    endproperty
    a_idle: assert property (p_idle) else $error("read data outside read");
    property p_pend;
        1'b1 |=> pending_0 == $past(flags_0_in & enables_0 & prio_on);
    endproperty
    a_pend: assert property (p_pend) else $error("pending wrong");
endmodule : ifeb_bank_sva
bind ifeb_bank ifeb_bank_sva u_sva (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .src_set(src_set), .flags_0_in(flags_0_in), .prio_0(prio_0),
    .flags_out(flags_out), .enables_0(enables_0), .pending_0(pending_0), .irq(irq));
`default_nettype wire

// ===== verif/ifeb_src_model.sv
// Peripheral source model that pulses flag set lines
`timescale 1ns/1ps
`default_nettype none
module ifeb_src_model (
    input  wire logic                        mclk,
    input  wire logic                        sys_rst,
    input  wire logic                        go,
    input  wire ifeb_pkg::ifeb_flag_set_type cmd,
    output var  ifeb_pkg::ifeb_flag_set_type src_set
);
    import ifeb_pkg::*;
    // One-cycle request pulse per commanded source
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            src_set <= '0;
        end else begin
            src_set <= go ? cmd : '0;
        end
    end
endmodule : ifeb_src_model
`default_nettype wire

// ===== verif/tb_ifeb_bank.sv
// Self-checking bench for the flag and enable bank
`timescale 1ns/1ps
`default_nettype none
module tb_ifeb_bank;
    import ifeb_pkg::*;
    logic mclk, sys_rst, go, irq;
    ifeb_bus_req_type bus_req;
    ifeb_flag_set_type cmd, src_set, flags_out;
    logic [DATA_W-1:0] bus_rdata, flags_0_in, enables_0, pending_0;
    ifeb_prio_type prio_0;
    int n_fail, cmp_count;
    localparam logic [DATA_W-1:0] MASKS [5] = '{MASK_FLAGS_1, MASK_FLAGS_2, MASK_FLAGS_3,
        MASK_FLAGS_4, MASK_ENABLES_0};
    ifeb_bank dut_u (.mclk(mclk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .src_set(src_set), .flags_0_in(flags_0_in), .prio_0(prio_0), .flags_out(flags_out),
        .enables_0(enables_0), .pending_0(pending_0), .irq(irq));
    ifeb_src_model src_u (.mclk(mclk), .sys_rst(sys_rst), .go(go), .cmd(cmd), .src_set(src_set));
    // ************************************************************
    // Bus, source and compare tasks
    // ************************************************************
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus_req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge mclk);
        bus_req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1;
        chk(bus_rdata, exp);
    endtask : rd
    task automatic fire(input ifeb_flag_set_type c);
        @(posedge mclk);
        go <= 1'b1;
        cmd <= c;
        @(posedge mclk);
        go <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
    endtask : fire
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        for (int a = 0; a < 8; a++) rd(a[2:0], 16'h0000);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_rw();
        for (int i = 0; i < 5; i++) begin
            wr(i[2:0], 16'hffff);
            rd(i[2:0], MASKS[i]);
            wr(i[2:0], 16'h0000);
            rd(i[2:0], 16'h0000);
        end
        wr(3'h7, 16'hffff);
        rd(3'h7, 16'h0000);
        $display("t_rw done");
    endtask : t_rw
    task automatic t_set();
        wr(OFS_EVT_MASK, 16'h0000);
        fire({MASK_FLAGS_1, MASK_FLAGS_2, MASK_FLAGS_3, MASK_FLAGS_4});
        chk({15'h0, irq}, 16'h0000);
        chk(flags_out.flags_2, MASK_FLAGS_2);
        for (int i = 0; i < 4; i++) rd(i[2:0], MASKS[i]);
        rd(OFS_EVT_STATUS, 16'h000f);
        rd(OFS_EVT_STATUS, 16'h0000);
        for (int i = 0; i < 4; i++) wr(i[2:0], 16'h0000);
        rd(OFS_FLAGS_1, 16'h0000);
        $display("t_set done");
    endtask : t_set
    task automatic t_irq();
        wr(OFS_EVT_MASK, 16'h0004);
        fire({16'h0, 16'h0, 16'h4000, 16'h0});
        chk({15'h0, irq}, 16'h0001);
        fire({16'h0, 16'h0020, 16'h0, 16'h0});
        rd(OFS_EVT_STATUS, 16'h0006);
        @(posedge mclk);
        #1;
        chk({15'h0, irq}, 16'h0000);
        rd(OFS_FLAGS_3, 16'h4000);
        $display("t_irq done");
    endtask : t_irq
    task automatic t_race();
        @(posedge mclk);
        go <= 1'b1;
        cmd <= {16'h0001, 16'h0000, 16'h0000, 16'h0000};
        @(posedge mclk);
        go <= 1'b0;
        bus_req <= '{addr: OFS_FLAGS_1, wdata: 16'h0000, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        go <= 1'b1;
        cmd <= {16'h0000, 16'h0000, 16'h0000, 16'h0002};
        bus_req.wr <= 1'b0;
        @(posedge mclk);
        go <= 1'b0;
        bus_req <= '{addr: OFS_EVT_STATUS, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus_req.rd <= 1'b0;
        #1;
        chk(bus_rdata, 16'h0001);
        wr(OFS_EVT_MASK, 16'h0008);
        #1;
        chk({15'h0, irq}, 16'h0001);
        rd(OFS_EVT_STATUS, 16'h0008);
        rd(OFS_FLAGS_1, 16'h0001);
        chk(flags_out.flags_4, 16'h0002);
        chk({15'h0, irq}, 16'h0000);
        $display("t_race done");
    endtask : t_race
    task automatic t_pend();
        ifeb_prio_type p;
        p = {16{3'h1}};
        p[BIT_TIMER_ONE_ENABLE] = 3'h0;
        wr(OFS_ENABLES_0, 16'hffff);
        prio_0 <= p;
        flags_0_in <= 16'hffff;
        repeat (2) @(posedge mclk);
        #1;
        chk(pending_0, 16'h3fe7);
        chk(enables_0, MASK_ENABLES_0);
        wr(OFS_ENABLES_0, 16'h0001);
        repeat (2) @(posedge mclk);
        #1;
        chk(pending_0, 16'h0001);
        $display("t_pend done");
    endtask : t_pend
    task automatic stop_test();
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test
    initial begin
        sys_rst = 1'b1;
        go = 1'b0;
        cmd = '0;
        bus_req = '0;
        flags_0_in = '0;
        prio_0 = '0;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_rw();
        t_set();
        t_irq();
        t_race();
        t_pend();
        stop_test();
    end
    initial begin
        #20000;
        n_fail++;
        stop_test();
    end
endmodule : tb_ifeb_bank
`default_nettype wire
